// File: hdl/atlc_core.sv
// module: converter trigger arbitration, result capture and limit check
`timescale 1ns/100ps
module atlc_core
(
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic [7:0]       sar_code,
    input  wire logic             analog_inputs_equal,
    output logic                  sample_strobe,
    input  wire logic             spi_start,
    input  wire logic             clear_status_command,
    input  wire logic             clear_limit_errors,
    input  wire logic             external_trigger_pin,
    input  wire logic             external_trigger_enable,
    input  wire logic             pwm_hard,
    input  wire logic             config_write_unlock,
    input  wire logic             config_write,
    input  wire atlc_pkg::atlc_src_t wr_trigger_source_select,
    input  wire logic [7:0]       wr_pwm_trigger_delay,
    input  wire logic             wr_current_source_enable,
    input  wire logic [1:0]       wr_gain_select,
    input  wire logic [1:0]       wr_offset_select,
    input  wire logic             wr_limit_fault_escalation,
    input  wire logic             limit_write,
    input  wire logic [5:0]       wr_lower_limit,
    input  wire logic [5:0]       wr_upper_limit,
    input  wire logic             primary_limit_fault_escalation,
    output logic [7:0]            conversion_result,
    output logic                  result_valid_flag,
    output logic                  busy,
    output logic                  under_limit_error,
    output logic                  over_limit_error,
    output logic                  limit_violation_status,
    output logic                  fault_notify_primary,
    output logic                  current_source_enable,
    output logic [1:0]            gain_select,
    output logic [1:0]            offset_select,
    output logic                  limit_fault_escalation,
    output atlc_pkg::atlc_src_t   trigger_source_select,
    output logic [7:0]            pwm_trigger_delay,
    output logic [5:0]            lower_limit,
    output logic [5:0]            upper_limit
);
    import atlc_pkg::*;

    atlc_state_t state;
    logic [7:0]  conv_count;
    logic [31:0] per_count;
    logic        ext_q;
    logic        per_trig;
    logic        pwm_trig;
    logic        any_trig;
    logic        accept;
    logic        done;
    logic [7:0]  lo_thr;
    logic [7:0]  hi_thr;
    logic        is_under;
    logic        is_over;

    function automatic logic [7:0] pad_limit(input logic [5:0] lim, input logic [1:0] ext);
        pad_limit = {lim, ext};
    endfunction : pad_limit

    // configuration, locked unless unlock bit is one
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            trigger_source_select  <= ATLC_TRIG_NONE;
            pwm_trigger_delay      <= PWMD_RESET;
            current_source_enable  <= 1'b0;
            gain_select            <= GAIN_RESET;
            offset_select          <= OFFSET_RESET;
            limit_fault_escalation <= 1'b0;
        end else if (config_write && config_write_unlock) begin
            trigger_source_select  <= wr_trigger_source_select;
            pwm_trigger_delay      <= wr_pwm_trigger_delay;
            current_source_enable  <= wr_current_source_enable;
            gain_select            <= wr_gain_select;
            offset_select          <= wr_offset_select;
            limit_fault_escalation <= wr_limit_fault_escalation;
        end
    end

    // reset limits span the whole code range, so no result can flag
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lower_limit <= LOWER_LIMIT_RESET;
            upper_limit <= UPPER_LIMIT_RESET;
        end else if (limit_write && config_write_unlock) begin
            lower_limit <= wr_lower_limit;
            upper_limit <= wr_upper_limit;
        end
    end

    // periodic source free-runs while selected
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            per_count <= 32'h0;
            per_trig  <= 1'b0;
        end else begin
            per_trig <= 1'b0;
            if (trigger_source_select != ATLC_TRIG_PERIODIC) begin
                per_count <= 32'h0;
            end else if (per_count == 32'(PERIODIC_CYCLES - 1)) begin
                per_count <= 32'h0;
                per_trig  <= 1'b1;
            end else begin
                per_count <= per_count + 32'h1;
            end
        end
    end

    // no reset: tracking the pin through reset keeps a pin already high from faking an edge
    always_ff @(posedge clk_sys) begin
        ext_q <= external_trigger_pin;
    end

    atlc_pwm_delay u_pwm (
        .clk_sys           (clk_sys),
        .rst               (rst),
        .pwm_hard          (pwm_hard),
        .enable            (trigger_source_select == ATLC_TRIG_PWM_RISE ||
                            trigger_source_select == ATLC_TRIG_PWM_FALL),
        .falling           (trigger_source_select == ATLC_TRIG_PWM_FALL),
        .pwm_trigger_delay (pwm_trigger_delay),
        .trig              (pwm_trig)
    );

    always_comb begin
        any_trig = spi_start
                 || (external_trigger_enable && external_trigger_pin && !ext_q)
                 || per_trig || pwm_trig;
        accept = any_trig && (state == ATLC_IDLE);
        done   = (state == ATLC_CONVERT) && (conv_count == 8'h00);
        busy   = (state != ATLC_IDLE);
        sample_strobe = accept;
    end

    // conversion sequencer; triggers outside idle are simply dropped
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state      <= ATLC_IDLE;
            conv_count <= 8'h00;
        end else begin
            case (state)
                ATLC_IDLE: begin
                    if (accept) begin
                        state      <= ATLC_CONVERT;
                        conv_count <= 8'(CONV_CYCLES - 1);
                    end
                end
                ATLC_CONVERT: begin
                    if (done) begin
                        state <= ATLC_DONE;
                    end else begin
                        conv_count <= conv_count - 8'h01;
                    end
                end
                ATLC_DONE: state <= ATLC_IDLE;
                default: state <= ATLC_IDLE;
            endcase
        end
    end

    // result and valid flag update in the same cycle; set wins over clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            conversion_result <= RESULT_RESET;
            result_valid_flag <= 1'b0;
        end else if (done) begin
            conversion_result <= analog_inputs_equal ? 8'h00 : sar_code;
            result_valid_flag <= 1'b1;
        end else if (clear_status_command) begin
            result_valid_flag <= 1'b0;
        end
    end

    always_comb begin
        lo_thr   = pad_limit(lower_limit, LOWER_EXT_BITS);
        hi_thr   = pad_limit(upper_limit, UPPER_EXT_BITS);
        is_under = (conversion_result < lo_thr) && (conversion_result < hi_thr);
        is_over  = (conversion_result > lo_thr) && (conversion_result > hi_thr);
    end

    // checked in the cycle after a new result lands
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            under_limit_error <= 1'b0;
            over_limit_error  <= 1'b0;
        end else begin
            if (state == ATLC_DONE && is_under) begin
                under_limit_error <= 1'b1;
            end else if (clear_limit_errors) begin
                under_limit_error <= 1'b0;
            end
            if (state == ATLC_DONE && is_over) begin
                over_limit_error <= 1'b1;
            end else if (clear_limit_errors) begin
                over_limit_error <= 1'b0;
            end
        end
    end

    always_comb begin
        limit_violation_status = under_limit_error || over_limit_error;
        // state machine side of the notify pin lives elsewhere
        fault_notify_primary = limit_violation_status &&
                               (limit_fault_escalation || primary_limit_fault_escalation);
    end

    property p_busy_drops;
        @(posedge clk_sys) disable iff (rst)
        accept |=> (busy && !sample_strobe) [*8];
    endproperty
    a_busy_drops: assert property (p_busy_drops) else $error("trigger accepted while busy");

    property p_done_valid;
        @(posedge clk_sys) disable iff (rst)
        accept |-> ##(CONV_CYCLES) done ##1 result_valid_flag;
    endproperty
    a_done_valid: assert property (p_done_valid) else $error("valid not set after conversion");

    property p_valid_hold;
        @(posedge clk_sys) disable iff (rst)
        result_valid_flag && !clear_status_command |=> result_valid_flag;
    endproperty
    a_valid_hold: assert property (p_valid_hold) else $error("valid dropped without clear");

    property p_clear_valid;
        @(posedge clk_sys) disable iff (rst)
        clear_status_command && !done |=> !result_valid_flag;
    endproperty
    a_clear_valid: assert property (p_clear_valid) else $error("clear ignored");

    property p_zero_code;
        @(posedge clk_sys) disable iff (rst)
        done && analog_inputs_equal |=> conversion_result == 8'h00;
    endproperty
    a_zero_code: assert property (p_zero_code) else $error("equal inputs not zero");

    property p_under;
        @(posedge clk_sys) disable iff (rst)
        state == ATLC_DONE && conversion_result < {lower_limit, 2'h0}
            && conversion_result < {upper_limit, 2'h3} |=> under_limit_error;
    endproperty
    a_under: assert property (p_under) else $error("under flag missing");

    property p_over;
        @(posedge clk_sys) disable iff (rst)
        state == ATLC_DONE && conversion_result > {lower_limit, 2'h0}
            && conversion_result > {upper_limit, 2'h3} |=> over_limit_error;
    endproperty
    a_over: assert property (p_over) else $error("over flag missing");

    property p_locked;
        @(posedge clk_sys) disable iff (rst)
        !config_write_unlock |=> $stable(lower_limit) && $stable(upper_limit)
            && $stable(gain_select);
    endproperty
    a_locked: assert property (p_locked) else $error("locked write took effect");

    property p_ext_ignored;
        @(posedge clk_sys) disable iff (rst)
        !external_trigger_enable && !spi_start && !per_trig && !pwm_trig |-> !sample_strobe;
    endproperty
    a_ext_ignored: assert property (p_ext_ignored) else $error("disabled pin triggered");

    property p_notify;
        @(posedge clk_sys) disable iff (rst)
        limit_fault_escalation && limit_violation_status |-> fault_notify_primary;
    endproperty
    a_notify: assert property (p_notify) else $error("notify not asserted");

    property p_notify_quiet;
        @(posedge clk_sys) disable iff (rst)
        !limit_violation_status |-> !fault_notify_primary;
    endproperty
    a_notify_quiet: assert property (p_notify_quiet) else $error("notify without violation");
endmodule : atlc_core

// File: hdl/atlc_pkg.sv
// package: constants and types for the converter trigger and limit check block
package atlc_pkg;
    localparam int          CLK_MHZ            = 200;
    localparam int          PERIODIC_US        = 100;
    localparam int          PERIODIC_CYCLES    = PERIODIC_US * CLK_MHZ;
    localparam int          CONV_CYCLES        = 10;
    localparam int          PWMD_UNIT_CYCLES   = 8;
    localparam logic [7:0]  RESULT_RESET       = 8'h00;
    localparam logic [5:0]  LOWER_LIMIT_RESET  = 6'h00;
    localparam logic [5:0]  UPPER_LIMIT_RESET  = 6'h3f;
    localparam logic [1:0]  LOWER_EXT_BITS     = 2'h0;
    localparam logic [1:0]  UPPER_EXT_BITS     = 2'h3;
    localparam logic [7:0]  PWMD_RESET         = 8'h00;
    localparam logic [1:0]  GAIN_RESET         = 2'h0;
    localparam logic [1:0]  OFFSET_RESET       = 2'h0;

    typedef enum logic [1:0] {
        ATLC_TRIG_NONE,
        ATLC_TRIG_PERIODIC,
        ATLC_TRIG_PWM_RISE,
        ATLC_TRIG_PWM_FALL
    } atlc_src_t;

    typedef enum logic [1:0] {
        ATLC_IDLE,
        ATLC_CONVERT,
        ATLC_DONE
    } atlc_state_t;
endpackage : atlc_pkg

// File: hdl/atlc_pwm_delay.sv
// module: pwm edge detect and programmable trigger delay
`timescale 1ns/100ps
module atlc_pwm_delay
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        pwm_hard,
    input  wire logic        enable,
    input  wire logic        falling,
    input  wire logic [7:0]  pwm_trigger_delay,
    output logic             trig
);
    import atlc_pkg::*;
    logic        pwm_q;
    logic        armed;
    logic [15:0] count;
    logic        edge_seen;

    // the input is the hard on/off state, so plateau steps never look like edges
    always_comb begin
        edge_seen = enable && (falling ? (pwm_q && !pwm_hard) : (!pwm_q && pwm_hard));
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pwm_q <= 1'b0;
        end else begin
            pwm_q <= pwm_hard;
        end
    end

    // a new edge restarts the wait; only the latest edge produces a trigger
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            armed <= 1'b0;
            count <= 16'h0000;
            trig  <= 1'b0;
        end else begin
            trig <= 1'b0;
            if (edge_seen) begin
                armed <= 1'b1;
                count <= 16'(pwm_trigger_delay) * 16'(PWMD_UNIT_CYCLES);
            end else if (armed) begin
                if (count == 16'h0000) begin
                    armed <= 1'b0;
                    trig  <= 1'b1;
                end else begin
                    count <= count - 16'h0001;
                end
            end
        end
    end

    property p_pwm_delay;
        @(posedge clk_sys) disable iff (rst)
        (edge_seen && pwm_trigger_delay == 8'h00) ##1 !edge_seen |=> trig;
    endproperty
    a_pwm_delay: assert property (p_pwm_delay) else $error("pwm trigger missing");
endmodule : atlc_pwm_delay

// File: verification/atlc_host.sv
// host model: command pulses and configuration writes
`timescale 1ns/100ps
module atlc_host
(
    input  wire logic           clk_sys,
    output logic                spi_start,
    output logic                clear_status_command,
    output logic                clear_limit_errors,
    output logic                config_write,
    output atlc_pkg::atlc_src_t wr_trigger_source_select,
    output logic [7:0]          wr_pwm_trigger_delay,
    output logic                wr_current_source_enable,
    output logic [1:0]          wr_gain_select,
    output logic [1:0]          wr_offset_select,
    output logic                wr_limit_fault_escalation,
    output logic                limit_write,
    output logic [5:0]          wr_lower_limit,
    output logic [5:0]          wr_upper_limit
);
    import atlc_pkg::*;
    initial begin
        {spi_start, clear_status_command, clear_limit_errors} = 3'h0;
        {config_write, limit_write} = 2'h0;
        wr_trigger_source_select = ATLC_TRIG_NONE;
        wr_pwm_trigger_delay = 8'h00;
        {wr_current_source_enable, wr_gain_select, wr_offset_select} = 5'h00;
        wr_limit_fault_escalation = 1'b0;
        {wr_lower_limit, wr_upper_limit} = 12'h000;
    end
    // one-cycle pulses: 0 start, 1 clear valid, 2 clear limit flags
    task automatic cmd(input int which);
        @(posedge clk_sys);
        case (which)
            0: spi_start <= 1'b1;
            1: clear_status_command <= 1'b1;
            default: clear_limit_errors <= 1'b1;
        endcase
        @(posedge clk_sys);
        {spi_start, clear_status_command, clear_limit_errors} <= 3'h0;
    endtask : cmd
    // misc packs source enable, gain, offset, escalation
    task automatic cfg(input atlc_src_t src, input logic [7:0] dly, input logic [5:0] misc);
        @(posedge clk_sys);
        config_write <= 1'b1;
        wr_trigger_source_select <= src;
        wr_pwm_trigger_delay <= dly;
        {wr_current_source_enable, wr_gain_select, wr_offset_select,
            wr_limit_fault_escalation} <= misc;
        @(posedge clk_sys);
        config_write <= 1'b0;
    endtask : cfg
    task automatic lim(input logic [5:0] lo, input logic [5:0] hi);
        @(posedge clk_sys);
        limit_write <= 1'b1;
        wr_lower_limit <= lo;
        wr_upper_limit <= hi;
        @(posedge clk_sys);
        limit_write <= 1'b0;
    endtask : lim
endmodule : atlc_host

// File: verification/tb_top.sv
// testbench: trigger sources, result capture and limit check
`timescale 1ns/100ps
module tb_top;
    import atlc_pkg::*;
    logic       clk_sys = 1'b0;
    logic       rst, analog_inputs_equal, external_trigger_pin, external_trigger_enable;
    logic       pwm_hard, config_write_unlock, primary_limit_fault_escalation;
    logic       spi_start, clear_status_command, clear_limit_errors, config_write;
    logic       limit_write, wr_current_source_enable, wr_limit_fault_escalation;
    logic       sample_strobe, busy, result_valid_flag, under_limit_error, over_limit_error;
    logic       limit_violation_status, fault_notify_primary, current_source_enable;
    logic       limit_fault_escalation;
    logic [7:0] sar_code, wr_pwm_trigger_delay, conversion_result, pwm_trigger_delay;
    logic [1:0] wr_gain_select, wr_offset_select, gain_select, offset_select;
    logic [5:0] wr_lower_limit, wr_upper_limit, lower_limit, upper_limit;
    atlc_src_t  wr_trigger_source_select, trigger_source_select;
    int         errors = 0, cmp_count = 0, strobes = 0, n, k0;
    logic [7:0] codes [4] = '{8'h3f, 8'h40, 8'h83, 8'h84};
    logic [7:0] flags [4] = '{8'h02, 8'h00, 8'h00, 8'h01};

    always #2.5 clk_sys = ~clk_sys;
    atlc_core atlc_core_i (
        .clk_sys                        (clk_sys),
        .rst                            (rst),
        .sar_code                       (sar_code),
        .analog_inputs_equal            (analog_inputs_equal),
        .sample_strobe                  (sample_strobe),
        .spi_start                      (spi_start),
        .clear_status_command           (clear_status_command),
        .clear_limit_errors             (clear_limit_errors),
        .external_trigger_pin           (external_trigger_pin),
        .external_trigger_enable        (external_trigger_enable),
        .pwm_hard                       (pwm_hard),
        .config_write_unlock            (config_write_unlock),
        .config_write                   (config_write),
        .wr_trigger_source_select       (wr_trigger_source_select),
        .wr_pwm_trigger_delay           (wr_pwm_trigger_delay),
        .wr_current_source_enable       (wr_current_source_enable),
        .wr_gain_select                 (wr_gain_select),
        .wr_offset_select               (wr_offset_select),
        .wr_limit_fault_escalation      (wr_limit_fault_escalation),
        .limit_write                    (limit_write),
        .wr_lower_limit                 (wr_lower_limit),
        .wr_upper_limit                 (wr_upper_limit),
        .primary_limit_fault_escalation (primary_limit_fault_escalation),
        .conversion_result              (conversion_result),
        .result_valid_flag              (result_valid_flag),
        .busy                           (busy),
        .under_limit_error              (under_limit_error),
        .over_limit_error               (over_limit_error),
        .limit_violation_status         (limit_violation_status),
        .fault_notify_primary           (fault_notify_primary),
        .current_source_enable          (current_source_enable),
        .gain_select                    (gain_select),
        .offset_select                  (offset_select),
        .limit_fault_escalation         (limit_fault_escalation),
        .trigger_source_select          (trigger_source_select),
        .pwm_trigger_delay              (pwm_trigger_delay),
        .lower_limit                    (lower_limit),
        .upper_limit                    (upper_limit)
    );
    atlc_host atlc_host_i (
        .clk_sys                   (clk_sys),
        .spi_start                 (spi_start),
        .clear_status_command      (clear_status_command),
        .clear_limit_errors        (clear_limit_errors),
        .config_write              (config_write),
        .wr_trigger_source_select  (wr_trigger_source_select),
        .wr_pwm_trigger_delay      (wr_pwm_trigger_delay),
        .wr_current_source_enable  (wr_current_source_enable),
        .wr_gain_select            (wr_gain_select),
        .wr_offset_select          (wr_offset_select),
        .wr_limit_fault_escalation (wr_limit_fault_escalation),
        .limit_write               (limit_write),
        .wr_lower_limit            (wr_lower_limit),
        .wr_upper_limit            (wr_upper_limit)
    );
    always @(posedge clk_sys) if (sample_strobe === 1'b1) strobes++;

    task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk_val
    task automatic chk_cnt(input string what, input int exp, input int got);
        cmp_count++;
        if (got != exp) begin
            errors++;
            $display("unexpected %s: expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_cnt
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic settle;
        @(posedge clk_sys);
        #1;
    endtask : settle
    // bounded waits; running out counts as a mismatch
    task automatic wait_strobe(input int lim);
        n = 0;
        #1;
        while (sample_strobe !== 1'b1) begin
            settle;
            n++;
            if (n > lim) begin
                errors++;
                print_verdict;
            end
        end
    endtask : wait_strobe
    task automatic wait_idle;
        int k;
        k = 0;
        settle;
        while (busy !== 1'b0) begin
            settle;
            k++;
            if (k > 40) begin
                errors++;
                print_verdict;
            end
        end
        settle;
    endtask : wait_idle
    task automatic convert(input logic [7:0] code);
        @(posedge clk_sys);
        sar_code <= code;
        atlc_host_i.cmd(0);
        wait_idle;
    endtask : convert

    initial begin
        rst = 1'b1;
        {analog_inputs_equal, external_trigger_pin, external_trigger_enable} = 3'h0;
        {pwm_hard, config_write_unlock, primary_limit_fault_escalation} = 3'h0;
        sar_code = 8'h00;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        settle;
        chk_val("upper_limit", 8'h3f, {2'h0, upper_limit});
        convert(8'hff);
        chk_val("flags", 8'h00, {6'h0, under_limit_error, over_limit_error});
        convert(8'h00);
        chk_val("flags", 8'h00, {6'h0, under_limit_error, over_limit_error});
        chk_val("valid", 8'h01, {7'h0, result_valid_flag});
        atlc_host_i.lim(6'h10, 6'h20);
        settle;
        chk_val("lower_limit", 8'h00, {2'h0, lower_limit});
        config_write_unlock <= 1'b1;
        atlc_host_i.lim(6'h10, 6'h20);
        settle;
        chk_val("upper_limit", 8'h20, {2'h0, upper_limit});
        $display("test reset_and_lock done");
        // thresholds 0x40 and 0x83, equality passes
        for (int i = 0; i < 4; i++) begin
            convert(codes[i]);
            chk_val("result", codes[i], conversion_result);
            chk_val("flags", flags[i], {6'h0, under_limit_error, over_limit_error});
            atlc_host_i.cmd(2);
            settle;
        end
        convert(8'hf0);
        convert(8'h50);
        chk_val("over", 8'h01, {7'h0, over_limit_error});
        atlc_host_i.cfg(ATLC_TRIG_NONE, 8'h00, 6'b1_10_01_1);
        settle;
        chk_val("notify", 8'h01, {7'h0, fault_notify_primary});
        chk_val("status", 8'h01, {7'h0, limit_violation_status});
        chk_val("mirrors", 8'h39, {2'h0, limit_fault_escalation, current_source_enable,
            gain_select, offset_select});
        atlc_host_i.cfg(ATLC_TRIG_NONE, 8'h00, 6'h00);
        settle;
        chk_val("notify", 8'h00, {7'h0, fault_notify_primary});
        chk_val("source", 8'h00, {7'h0, current_source_enable});
        primary_limit_fault_escalation <= 1'b1;
        settle;
        chk_val("notify", 8'h01, {7'h0, fault_notify_primary});
        atlc_host_i.cmd(2);
        atlc_host_i.cmd(1);
        settle;
        chk_val("clears", 8'h00, {5'h0, limit_violation_status, result_valid_flag,
            over_limit_error});
        analog_inputs_equal <= 1'b1;
        convert(8'hc5);
        chk_val("result", 8'h00, conversion_result);
        analog_inputs_equal <= 1'b0;
        $display("test limits done");
        // second start lands while busy and is dropped
        k0 = strobes;
        atlc_host_i.cmd(0);
        atlc_host_i.cmd(0);
        wait_idle;
        chk_cnt("strobes", 1, strobes - k0);
        k0 = strobes;
        external_trigger_pin <= 1'b1;
        repeat (3) settle;
        external_trigger_pin <= 1'b0;
        external_trigger_enable <= 1'b1;
        settle;
        external_trigger_pin <= 1'b1;
        repeat (3) settle;
        wait_idle;
        chk_cnt("strobes", 1, strobes - k0);
        $display("test triggers done");
        atlc_host_i.cfg(ATLC_TRIG_PWM_RISE, 8'h03, 6'h00);
        @(posedge clk_sys);
        pwm_hard <= 1'b1;
        wait_strobe(100);
        chk_cnt("pwm delay", 2 + PWMD_UNIT_CYCLES * 3, n);
        chk_val("pwm_trigger_delay", 8'h03, pwm_trigger_delay);
        chk_val("trigger_source_select", 8'h02, {6'h0, trigger_source_select});
        wait_idle;
        atlc_host_i.cfg(ATLC_TRIG_PWM_FALL, 8'h00, 6'h00);
        @(posedge clk_sys);
        pwm_hard <= 1'b0;
        wait_strobe(100);
        chk_cnt("pwm delay", 2, n);
        wait_idle;
        atlc_host_i.cfg(ATLC_TRIG_PERIODIC, 8'h00, 6'h00);
        wait_strobe(PERIODIC_CYCLES + 20);
        @(posedge clk_sys);
        wait_strobe(PERIODIC_CYCLES + 20);
        chk_cnt("period", PERIODIC_CYCLES, n + 1);
        $display("test modes done");
        // reset again with the pin held high: no false edge may follow
        rst <= 1'b1;
        repeat (2) settle;
        rst <= 1'b0;
        k0 = strobes;
        repeat (4) settle;
        chk_cnt("strobes", 0, strobes - k0);
        chk_val("status", 8'h00, {4'h0, busy, result_valid_flag, under_limit_error,
            over_limit_error});
        chk_val("result", 8'h00, conversion_result);
        chk_val("lower_limit", 8'h00, {2'h0, lower_limit});
        chk_val("trigger_source_select", 8'h00, {6'h0, trigger_source_select});
        $display("test reset_again done");
        print_verdict;
    end
endmodule : tb_top
